// *** rtl/ipc_interrupt_priority_control.sv ***
/*
 * Interrupt priority control: enable registers with pending flags and
 * levels, input mode control, DMA start vectors, priority resolution
 * toward the core, and a sticky status with mask onto one interrupt line.
 * Assumes an APB master on the same clock, peripheral request pulses on
 * the same clock, and asynchronous external pins.
 */
`include "ipc_defines.svh"

module ipc_interrupt_priority_control (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Peripheral request pulses
	input  wire logic [`IPC_NSRC-1:0] srcPulse,
	// External pins
	input  wire logic [`IPC_NEXT-1:0] extPin,
	input  wire logic                 nmiPin,
	// Core side
	output logic                      cpuReq,
	output logic      [2:0]           cpuLevel,
	output logic      [5:0]           cpuVector,
	input  wire logic                 intAck,
	output logic                      nmiReq,
	input  wire logic                 nmiAck,
	// DMA side
	output logic      [`IPC_NDMA-1:0] dmaStart,
	// Interrupt line
	output logic                      irqOut
);

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------

	// Address index to decode slot
	function automatic logic [4:0] slotOf(input logic [9:0] idx);
		logic [4:0] s;
		s = `IPC_SLOT_NONE;
		unique case (idx)
			`IPC_IDX_TIMER7_6:    s = 5'h00;
			`IPC_IDX_TIMER9_8:    s = 5'h01;
			`IPC_IDX_TIMERB_A:    s = 5'h02;
			`IPC_IDX_TOUT6_4:     s = 5'h03;
			`IPC_IDX_TOUTA_8:     s = 5'h04;
			`IPC_IDX_KEY_CLOCK:   s = 5'h05;
			`IPC_IDX_EXT0_ADC:    s = 5'h06;
			`IPC_IDX_EXT2_1:      s = 5'h07;
			`IPC_IDX_EXT4_3:      s = 5'h08;
			`IPC_IDX_EXT9_8:      s = 5'h09;
			`IPC_IDX_EXTB_A:      s = 5'h0A;
			`IPC_IDX_TIMER1_0:    s = 5'h0B;
			`IPC_IDX_TIMER3_2:    s = 5'h0C;
			`IPC_IDX_SERIAL0:     s = 5'h0D;
			`IPC_IDX_SERIAL1:     s = 5'h0E;
			`IPC_IDX_EXT7_SERBUS: s = 5'h0F;
			`IPC_IDX_TIMER5_4:    s = 5'h10;
			`IPC_IDX_INPUT_MODE:  s = `IPC_SLOT_MODE;
			`IPC_IDX_DMA_CH0:     s = 5'h12;
			`IPC_IDX_DMA_CH1:     s = 5'h13;
			`IPC_IDX_DMA_CH2:     s = 5'h14;
			`IPC_IDX_DMA_CH3:     s = 5'h15;
			`IPC_IDX_IRQ_STATUS:  s = `IPC_SLOT_STATUS;
			`IPC_IDX_IRQ_MASK:    s = `IPC_SLOT_MASK;
			`IPC_IDX_CURRENT:     s = `IPC_SLOT_CURRENT;
			default:              s = `IPC_SLOT_NONE;
		endcase
		return s;
	endfunction : slotOf

	// External pin number to source number
	function automatic logic [5:0] extSrcOf(input int p);
		logic [5:0] s;
		s = `IPC_SRC_EXT0;
		unique case (p)
			0:       s = `IPC_SRC_EXT0;
			1:       s = `IPC_SRC_EXT1;
			2:       s = `IPC_SRC_EXT2;
			3:       s = `IPC_SRC_EXT3;
			4:       s = `IPC_SRC_EXT4;
			5:       s = `IPC_SRC_EXT7;
			6:       s = `IPC_SRC_EXT8;
			7:       s = `IPC_SRC_EXT9;
			8:       s = `IPC_SRC_EXTA;
			default: s = `IPC_SRC_EXTB;
		endcase
		return s;
	endfunction : extSrcOf

	// ------------------------------------------------------------------------
	// State and next state
	// ------------------------------------------------------------------------
	ipc_pkg::ipc_state_type  st_r;
	ipc_pkg::ipc_state_type  st_nxt;
	logic [4:0]              slot;
	logic                    setupPh;
	logic                    writeEn;
	logic                    readEn;
	logic [`IPC_NPIN-1:0]    rise;
	logic [`IPC_NPIN-1:0]    fall;
	logic [`IPC_NEXT-1:0]    extEvt;
	logic [`IPC_NSRC-1:0]    evt;
	logic [`IPC_NSRC-1:0]    claim;
	logic [`IPC_NSRC-1:0]    setPend;
	logic [`IPC_NSRC-1:0]    clrPend;
	logic [`IPC_NREG-1:0]    setStat;
	logic [2:0]              winLvl;
	logic [5:0]              winIdx;
	logic                    anyValid;
	logic                    nmiEvt;
	logic [31:0]             rdMux;

	// Bus phase decode
	assign slot    = (paddr[11:2] < 10'h100) ? slotOf(paddr[11:2]) : `IPC_SLOT_NONE;
	assign setupPh = psel & ~penable;
	assign writeEn = psel & penable & pwrite;
	assign readEn  = psel & penable & ~pwrite;

	// Next state
	always_comb begin
		st_nxt   = st_r;
		extEvt   = '0;
		claim    = '0;
		clrPend  = '0;
		setStat  = '0;
		winLvl   = 3'h0;
		winIdx   = 6'h00;
		rdMux    = 32'h0000_0000;
		st_nxt.dmaStart = '0;

		// Two-stage pin synchronisers, then a history stage
		st_nxt.sync1 = {nmiPin, extPin};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev  = st_r.sync2;
		rise = st_r.sync2 & ~st_r.prev;
		fall = ~st_r.sync2 & st_r.prev;

		// [RL6] edge polarity select
		for (int p = 0; p < `IPC_NEXT; p++) begin
			if (p < `IPC_NFALL && st_r.mode[3'(`IPC_BIT_FALL_BASE + p)]) begin
				extEvt[p] = fall[p];
			end else begin
				extEvt[p] = rise[p];
			end
		end
		// [RL7] external zero level mode
		if (st_r.mode[`IPC_BIT_EXT0_LEVEL]) begin
			extEvt[0] = st_r.sync2[0];
		end

		// Merge peripheral pulses with pin events
		evt = srcPulse & ~`IPC_EXT_MASK;
		for (int p = 0; p < `IPC_NEXT; p++) begin
			evt[extSrcOf(p)] = extEvt[p];
		end

		// Claimed event skips the pending flag: no second service by the core
		// [RL9] start DMA channel on matching request
		for (int c = 0; c < `IPC_NDMA; c++) begin
			if (st_r.dmaVec[c] != 6'h00 && st_r.dmaVec[c] <= 6'(`IPC_NSRC)) begin
				if (evt[st_r.dmaVec[c] - 6'h01]) begin
					st_nxt.dmaStart[c] = 1'b1;
					claim[st_r.dmaVec[c] - 6'h01] = 1'b1;
				end
			end
		end
		setPend = evt & ~claim;

		// Core acknowledge retires the presented source
		if (intAck && st_r.cpuVec != 6'h00) begin
			clrPend[st_r.cpuVec - 6'h01] = 1'b1;
		end

		// Register writes
		if (writeEn && slot < 5'(`IPC_NREG)) begin
			// [RL5] two sources per enable register
			st_nxt.level[{slot, 1'b1}] = pwdata[6:4];
			st_nxt.level[{slot, 1'b0}] = pwdata[2:0];
			// [RL4] zero clears, one keeps
			clrPend[{slot, 1'b1}] = clrPend[{slot, 1'b1}] | ~pwdata[`IPC_BIT_UP_PEND];
			clrPend[{slot, 1'b0}] = clrPend[{slot, 1'b0}] | ~pwdata[`IPC_BIT_LO_PEND];
		end
		if (writeEn && slot == `IPC_SLOT_MODE) begin
			st_nxt.mode = pwdata[7:0];
		end
		if (writeEn && slot >= `IPC_SLOT_DMA0 && slot < `IPC_SLOT_STATUS) begin
			st_nxt.dmaVec[2'(slot - `IPC_SLOT_DMA0)] = pwdata[5:0];
		end
		if (writeEn && slot == `IPC_SLOT_MASK) begin
			st_nxt.mask = pwdata[`IPC_NREG-1:0];
		end

		// [RL3] flag held until cleared, new request wins
		st_nxt.pending = (st_r.pending & ~clrPend) | setPend;

		// Sticky status per enable register (its two sources), set wins
		for (int r = 0; r < `IPC_NREG; r++) begin
			setStat[r] = setPend[2 * r] | setPend[2 * r + 1];
		end
		// Read clears only the bits it returned; an event that lands
		// between setup and access stays for the next read
		if (readEn && slot == `IPC_SLOT_STATUS) begin
			st_nxt.status = (st_r.status & ~st_r.rdData[`IPC_NREG-1:0]) | setStat;
		end else begin
			st_nxt.status = st_r.status | setStat;
		end

		// [RL8] non-maskable edge detect
		nmiEvt = fall[`IPC_PIN_NMI] | (st_r.mode[`IPC_BIT_NMI_RISE] & rise[`IPC_PIN_NMI]);
		st_nxt.nmiReq = (st_r.nmiReq & ~nmiAck) | nmiEvt;

		// [RL10] highest level, lowest source on tie
		for (int i = 0; i < `IPC_NSRC; i++) begin
			// [RL2] codes 0 and 7 never compete
			if (st_r.pending[i] && st_r.level[i] != `IPC_LVL_OFF_LO
			    && st_r.level[i] != `IPC_LVL_OFF_HI && st_r.level[i] > winLvl) begin
				// [RL1] level code is request level
				winLvl = st_r.level[i];
				winIdx = 6'(i);
			end
		end
		anyValid        = (winLvl != 3'h0);
		st_nxt.cpuReq   = anyValid;
		st_nxt.cpuLevel = winLvl;
		st_nxt.cpuVec   = anyValid ? winIdx + 6'h01 : 6'h00;

		// Read data, captured in the setup phase
		// Level fields and write-only registers read as zero
		if (slot < 5'(`IPC_NREG)) begin
			rdMux[`IPC_BIT_UP_PEND] = st_r.pending[{slot, 1'b1}];
			rdMux[`IPC_BIT_LO_PEND] = st_r.pending[{slot, 1'b0}];
		end else if (slot == `IPC_SLOT_STATUS) begin
			rdMux[`IPC_NREG-1:0] = st_r.status;
		end else if (slot == `IPC_SLOT_MASK) begin
			rdMux[`IPC_NREG-1:0] = st_r.mask;
		end else if (slot == `IPC_SLOT_CURRENT) begin
			rdMux[5:0]  = st_r.cpuVec;
			rdMux[10:8] = st_r.cpuLevel;
			rdMux[15]   = st_r.cpuReq;
			rdMux[16]   = st_r.nmiReq;
		end
		if (setupPh) begin
			st_nxt.rdData = rdMux;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------

	// Zero-wait slave, error on unmapped index
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & (slot == `IPC_SLOT_NONE);
	assign prdata    = st_r.rdData;
	assign cpuReq    = st_r.cpuReq;
	assign cpuLevel  = st_r.cpuLevel;
	assign cpuVector = st_r.cpuVec;
	assign nmiReq    = st_r.nmiReq;
	assign dmaStart  = st_r.dmaStart;
	assign irqOut    = |(st_r.status & st_r.mask);

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic upWrClr;
	assign upWrClr = writeEn && slot < 5'(`IPC_NREG) && !pwdata[`IPC_BIT_UP_PEND]
	                 && !setPend[{slot, 1'b1}];

	chk_level_range: assert property (cpuReq |-> cpuLevel inside {[3'h1:3'h6]}) // [RL1]
		else $error("presented level outside 1 to 6");

	chk_prohibit_block: assert property (!anyValid |=> !cpuReq) // [RL2]
		else $error("request forwarded without a valid level");

	chk_pending_read: assert property (setupPh && slot < 5'(`IPC_NREG) // [RL3]
		|=> prdata[`IPC_BIT_UP_PEND] == $past(st_r.pending[{slot, 1'b1}]))
		else $error("pending flag read back wrong");

	chk_zero_clears: assert property (upWrClr |=> !st_r.pending[$past({slot, 1'b1})]) // [RL4]
		else $error("zero write did not clear flag");

	chk_field_store: assert property (writeEn && slot < 5'(`IPC_NREG) // [RL5]
		|=> st_r.level[$past({slot, 1'b0})] == $past(pwdata[2:0]))
		else $error("lower level field not stored");

	chk_edge_rise: assert property (!st_r.mode[3] && rise[1] |-> extEvt[1]) // [RL6]
		else $error("rising edge missed");

	chk_edge_fall: assert property (st_r.mode[3] && fall[1] |-> extEvt[1] && !rise[1]) // [RL6]
		else $error("falling edge missed");

	chk_level_mode: assert property (st_r.mode[1] && st_r.sync2[0] // [RL7]
		|=> st_r.pending[`IPC_SRC_EXT0] || $past(claim[`IPC_SRC_EXT0]))
		else $error("level mode did not hold request");

	chk_nmi_rise: assert property (st_r.mode[0] && rise[`IPC_PIN_NMI] |=> nmiReq) // [RL8]
		else $error("rising non-maskable edge missed");

	chk_dma_reset: assert property (disable iff (1'b0) !rst_n |=> st_r.dmaVec == '0) // [RL9]
		else $error("DMA vector not cleared by reset");

	chk_dma_start: assert property (st_r.dmaVec[2] == 6'h17 && evt[22] // [RL9]
		|=> dmaStart[2] ##1 (!dmaStart[2] || $past(st_r.dmaVec[2] == 6'h17 && evt[22])))
		else $error("DMA start not issued");

	chk_prio_win: assert property (anyValid |=> cpuReq && cpuLevel == $past(winLvl) // [RL10]
		&& cpuVector == $past(winIdx) + 6'h01)
		else $error("wrong source presented");

	chk_pending_low: assert property (setupPh && slot < 5'(`IPC_NREG) // [RL3]
		|=> prdata[`IPC_BIT_LO_PEND] == $past(st_r.pending[{slot, 1'b0}]))
		else $error("lower pending flag read back wrong");

	chk_field_upper: assert property (writeEn && slot < 5'(`IPC_NREG) // [RL5]
		|=> st_r.level[$past({slot, 1'b1})] == $past(pwdata[6:4]))
		else $error("upper level field not stored");

	chk_win_valid: assert property (anyValid // [RL2]
		|-> st_r.pending[winIdx] && st_r.level[winIdx] inside {[3'h1:3'h6]})
		else $error("winner not pending or at a blocked level");

	chk_nmi_fall: assert property (fall[`IPC_PIN_NMI] |=> nmiReq) // [RL8]
		else $error("falling non-maskable edge missed");

	chk_ack_clear: assert property (intAck && cpuVector != 6'h00 // [RL3]
		&& !setPend[cpuVector - 6'h01] |=> !st_r.pending[$past(cpuVector) - 6'h01])
		else $error("acknowledge did not retire the source");

	chk_dma_claim: assert property ((claim & ~st_r.pending) != '0 // [RL9]
		|=> (st_r.pending & $past(claim & ~st_r.pending)) == '0)
		else $error("claimed event left a pending flag");

	chk_status_set: assert property (setStat != '0
		|=> (st_r.status & $past(setStat)) == $past(setStat))
		else $error("status event lost");

	chk_status_kept: assert property (readEn && slot == `IPC_SLOT_STATUS
		|=> (st_r.status & $past(st_r.status & ~prdata[`IPC_NREG-1:0]))
		    == $past(st_r.status & ~prdata[`IPC_NREG-1:0]))
		else $error("status bit cleared before it was read");

	cov_cpu_req: cover property (!cpuReq ##1 cpuReq);
	cov_dma_go:  cover property (dmaStart != '0);
	cov_nmi:     cover property (nmiReq);
	cov_irq:     cover property (irqOut ##1 !irqOut);
	cov_level:   cover property (st_r.mode[`IPC_BIT_EXT0_LEVEL] && st_r.sync2[0]);

endmodule : ipc_interrupt_priority_control

// *** rtl/ipc_defines.svh ***
/*
 * Constants for the interrupt priority control block: register indices,
 * field positions, decode slots and reset values.
 * Assumes it is included by the package and the block; defines only.
 */
// Contract
// [RL1] Level codes 1..6 set request level
// [RL2] Level code 0 or 7 blocks request
// [RL3] Pending bit reads one while request outstanding
// [RL4] Write zero clears flag, one keeps
// [RL5] Bit7/6:4 upper source, bit3/2:0 lower
// [RL6] Edge select zero rising, one falling
// [RL7] External zero edge or level mode
// [RL8] Non-maskable input also rising when enabled
// [RL9] Four write-only six-bit DMA start vectors
// [RL10] Highest level wins, lowest source on tie
// [RL11] Software writes whole bytes, no bit ops
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define IPC_NREG        17
`define IPC_NSRC        34
`define IPC_NEXT        10
`define IPC_NPIN        11
`define IPC_NDMA        4

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IPC_IDX_TIMER7_6     10'h044
`define IPC_IDX_TIMER9_8     10'h045
`define IPC_IDX_TIMERB_A     10'h046
`define IPC_IDX_TOUT6_4      10'h047
`define IPC_IDX_TOUTA_8      10'h05A
`define IPC_IDX_KEY_CLOCK    10'h05B
`define IPC_IDX_EXT0_ADC     10'h070
`define IPC_IDX_EXT2_1       10'h071
`define IPC_IDX_EXT4_3       10'h072
`define IPC_IDX_EXT9_8       10'h073
`define IPC_IDX_EXTB_A       10'h074
`define IPC_IDX_TIMER1_0     10'h075
`define IPC_IDX_TIMER3_2     10'h076
`define IPC_IDX_SERIAL0      10'h077
`define IPC_IDX_SERIAL1      10'h078
`define IPC_IDX_EXT7_SERBUS  10'h079
`define IPC_IDX_TIMER5_4     10'h07A
`define IPC_IDX_INPUT_MODE   10'h07B
`define IPC_IDX_DMA_CH0      10'h07C
`define IPC_IDX_DMA_CH1      10'h07D
`define IPC_IDX_DMA_CH2      10'h07E
`define IPC_IDX_DMA_CH3      10'h07F
`define IPC_IDX_IRQ_STATUS   10'h080
`define IPC_IDX_IRQ_MASK     10'h081
`define IPC_IDX_CURRENT      10'h082

// ----------------------------------------------------------------------------
// Decode slots (0..16 are the enable registers)
// ----------------------------------------------------------------------------
`define IPC_SLOT_MODE    5'h11
`define IPC_SLOT_DMA0    5'h12
`define IPC_SLOT_STATUS  5'h16
`define IPC_SLOT_MASK    5'h17
`define IPC_SLOT_CURRENT 5'h18
`define IPC_SLOT_NONE    5'h1F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IPC_BIT_UP_PEND     7
`define IPC_BIT_LO_PEND     3
`define IPC_BIT_NMI_RISE    0
`define IPC_BIT_EXT0_LEVEL  1
`define IPC_BIT_FALL_BASE   2
`define IPC_NFALL           6
`define IPC_PIN_NMI         10
`define IPC_LVL_OFF_LO      3'h0
`define IPC_LVL_OFF_HI      3'h7

// ----------------------------------------------------------------------------
// Source numbers of external inputs (2 * register slot + upper)
// ----------------------------------------------------------------------------
`define IPC_SRC_EXT0  6'h0C
`define IPC_SRC_EXT1  6'h0E
`define IPC_SRC_EXT2  6'h0F
`define IPC_SRC_EXT3  6'h10
`define IPC_SRC_EXT4  6'h11
`define IPC_SRC_EXT7  6'h1F
`define IPC_SRC_EXT8  6'h12
`define IPC_SRC_EXT9  6'h13
`define IPC_SRC_EXTA  6'h14
`define IPC_SRC_EXTB  6'h15
`define IPC_EXT_MASK  34'h0_803F_D000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IPC_RST_REG   8'h00

`endif

// *** rtl/ipc_pkg.sv ***
/*
 * Types of the interrupt priority control block.
 * Assumes the constants header is on the include path.
 */
`include "ipc_defines.svh"

package ipc_pkg;

	// ------------------------------------------------------------------------
	// Whole state of the block
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [`IPC_NSRC-1:0][2:0] level;
		logic [`IPC_NSRC-1:0]      pending;
		logic [7:0]                mode;
		logic [`IPC_NDMA-1:0][5:0] dmaVec;
		logic [`IPC_NREG-1:0]      status;
		logic [`IPC_NREG-1:0]      mask;
		logic [`IPC_NPIN-1:0]      sync1;
		logic [`IPC_NPIN-1:0]      sync2;
		logic [`IPC_NPIN-1:0]      prev;
		logic                      nmiReq;
		logic                      cpuReq;
		logic [2:0]                cpuLevel;
		logic [5:0]                cpuVec;
		logic [`IPC_NDMA-1:0]      dmaStart;
		logic [31:0]               rdData;
	} ipc_state_type;

endpackage : ipc_pkg

// *** tb/ipc_core_model.sv ***
/*
 * Behavioural core model: acknowledges the presented request and the
 * non-maskable request of the interrupt priority control block.
 * Assumes the block's core-side ports and one shared clock.
 */
module ipc_core_model (
	// Clock
	input  wire logic       clock,
	// Bench control
	input  wire logic       ackEn,
	input  wire logic [2:0] ackDelay,
	// Core side of the block
	input  wire logic       cpuReq,
	input  wire logic       nmiReq,
	output logic            intAck,
	output logic            nmiAck
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------------
	// Acknowledge of maskable requests
	// ------------------------------------------------------------------------
	// Prompt or slow ack, then a pause so the vector can move on
	initial begin
		intAck = 1'b0;
		forever begin
			@(posedge clock);
			if (ackEn && cpuReq === 1'b1) begin
				repeat (ackDelay) @(posedge clock);
				intAck <= 1'b1;
				@(posedge clock);
				intAck <= 1'b0;
				repeat (3) @(posedge clock);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Acknowledge of non-maskable requests
	// ------------------------------------------------------------------------
	// One pulse per request, gap for the clear to land
	initial begin
		nmiAck = 1'b0;
		forever begin
			@(posedge clock);
			if (nmiReq === 1'b1) begin
				nmiAck <= 1'b1;
				@(posedge clock);
				nmiAck <= 1'b0;
				@(posedge clock);
			end
		end
	end
endmodule : ipc_core_model

// *** tb/tb_interrupt_priority_control.sv ***
/*
 * Self-checking bench of the interrupt priority control block.
 * Assumes the constants header on the include path and the core model.
 */
`include "ipc_defines.svh"

module tb_interrupt_priority_control;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------------
	logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, nmiPin = 1'b0, ackEn = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [33:0] srcPulse = '0;
	logic [9:0]  extPin = '0;
	logic [2:0]  ackDelay = 3'h0, cpuLevel;
	logic [5:0]  cpuVector;
	logic [3:0]  dmaStart;
	logic        pready, pslverr, cpuReq, intAck, nmiReq, nmiAck, irqOut;
	logic [32:0] readQ[$];
	logic [8:0]  ackQ[$];
	int          numErrors = 0, checkCount = 0, nmiCount = 0, dmaCount = 0;
	int          seed;

	ipc_interrupt_priority_control DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .srcPulse(srcPulse),
		.extPin(extPin), .nmiPin(nmiPin), .cpuReq(cpuReq), .cpuLevel(cpuLevel),
		.cpuVector(cpuVector), .intAck(intAck), .nmiReq(nmiReq), .nmiAck(nmiAck),
		.dmaStart(dmaStart), .irqOut(irqOut));
	ipc_core_model core (.clock(clock), .ackEn(ackEn), .ackDelay(ackDelay),
		.cpuReq(cpuReq), .nmiReq(nmiReq), .intAck(intAck), .nmiAck(nmiAck));

	// Clock of 100 ns period
	always #50 clock = ~clock;

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task check(input logic [32:0] got, input logic [32:0] exp, input string what);
		checkCount++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task results();
		$display("comparisons %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// One APB transfer, request held until pready, one idle edge after
	// whole-byte register writes
	task apb(input logic [9:0] idx, input logic wr, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task wr(input logic [9:0] idx, input logic [7:0] d);
		logic [23:0] junk;
		junk = 24'($random(seed));
		apb(idx, 1'b1, {junk, d});
	endtask : wr

	task rd(input logic [9:0] idx, input logic [31:0] exp, input logic err);
		readQ.push_back({err, exp});
		apb(idx, 1'b0, 32'h0);
	endtask : rd

	task pulse(input logic [33:0] m);
		srcPulse <= m;
		@(posedge clock);
		srcPulse <= '0;
		@(posedge clock);
	endtask : pulse

	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// Bounded wait until every noted acknowledge was seen
	task drain();
		int n;
		n = 0;
		while (ackQ.size() != 0 && n < 100) begin
			n++;
			@(posedge clock);
		end
		check(ackQ.size(), 0, "missing acknowledge");
		ackQ.delete();
		cyc(4);
	endtask : drain

	// ------------------------------------------------------------------------
	// Monitor: oldest note against each result
	// ------------------------------------------------------------------------
	always @(posedge clock) begin
		if (psel && penable && pready && !pwrite) begin
			check({pslverr, prdata}, readQ.pop_front(), "read");
		end
		if (intAck === 1'b1) begin
			check({cpuReq, cpuVector, cpuLevel}, {1'b1, ackQ.pop_front()}, "vector");
		end
		if (nmiAck === 1'b1 && nmiReq === 1'b1) begin
			nmiCount++;
		end
		if (dmaStart !== 4'h0) begin
			dmaCount += (dmaStart === 4'b0100) ? 1 : 100;
		end
	end

	// Watchdog
	initial begin
		#2000000;
		numErrors++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		seed = 16059;
		cyc(3);
		rst_n <= 1'b1;
		@(posedge clock);
		// Reset values, write-only reads and address decode
		for (int i = 'h44; i < 'h83; i++) begin
			rd(10'(i), 32'h0, !(i < 'h48 || i == 'h5A || i == 'h5B || i >= 'h70));
		end
		// Sticky status, mask and interrupt line
		apb(`IPC_IDX_IRQ_MASK, 1'b1, 32'h0000_0800);
		wr(`IPC_IDX_TIMER1_0, 8'h05);
		pulse(34'h0_1000_0000);
		cyc(2);
		check(irqOut, 0, "masked line");
		ackQ.push_back({6'h17, 3'h5});
		pulse(34'h0_0040_0000);
		cyc(2);
		check(irqOut, 1, "line");
		rd(`IPC_IDX_IRQ_STATUS, 32'h0000_4800, 1'b0);
		check(irqOut, 0, "line after read");
		drain();
		// Level codes 1 to 6 on the upper source, prompt and slow core
		for (int k = 1; k <= 6; k++) begin
			ackDelay <= 3'($random(seed));
			wr(`IPC_IDX_TIMER1_0, {1'b0, 3'(k), 4'h0});
			ackQ.push_back({6'h18, 3'(k)});
			pulse(34'h0_0080_0000);
			drain();
		end
		// Higher level first, then lowest source on a tie
		wr(`IPC_IDX_TIMER1_0, 8'h35);
		ackQ.push_back({6'h17, 3'h5});
		ackQ.push_back({6'h18, 3'h3});
		pulse(34'h0_00C0_0000);
		drain();
		wr(`IPC_IDX_TIMER3_2, 8'h44);
		ackQ.push_back({6'h19, 3'h4});
		ackQ.push_back({6'h1A, 3'h4});
		pulse(34'h0_0300_0000);
		drain();
		// Converter source, just above the external zero bit
		wr(`IPC_IDX_EXT0_ADC, 8'h60);
		ackQ.push_back({6'h0E, 3'h6});
		pulse(34'h0_0000_2000);
		drain();
		// Blocked levels, pending read and clear by zero
		wr(`IPC_IDX_SERIAL0, 8'h70);
		pulse(34'h0_0C00_0000);
		cyc(3);
		check(cpuReq, 0, "blocked level");
		rd(`IPC_IDX_SERIAL0, 32'h88, 1'b0);
		wr(`IPC_IDX_SERIAL0, 8'h80);
		rd(`IPC_IDX_SERIAL0, 32'h80, 1'b0);
		wr(`IPC_IDX_SERIAL0, 8'h00);
		rd(`IPC_IDX_SERIAL0, 32'h00, 1'b0);
		// Falling select on one pin, rising on the next
		wr(`IPC_IDX_INPUT_MODE, 8'h08);
		extPin <= 10'h006;
		cyc(6);
		rd(`IPC_IDX_EXT2_1, 32'h80, 1'b0);
		extPin <= 10'h000;
		cyc(6);
		rd(`IPC_IDX_EXT2_1, 32'h88, 1'b0);
		// Level mode re-arms while high, edge mode only once
		for (int m = 0; m < 3; m++) begin
			wr(`IPC_IDX_INPUT_MODE, (m == 2) ? 8'h00 : 8'h02);
			extPin <= (m == 1) ? 10'h000 : 10'h001;
			cyc(6);
			wr(`IPC_IDX_EXT0_ADC, 8'h00);
			rd(`IPC_IDX_EXT0_ADC, (m == 0) ? 32'h08 : 32'h00, 1'b0);
		end
		extPin <= 10'h000;
		// Non-maskable input, rising edge off then on
		nmiPin <= 1'b1;
		cyc(8);
		check(nmiCount, 0, "nmi rise ignored");
		nmiPin <= 1'b0;
		cyc(8);
		check(nmiCount, 1, "nmi fall");
		wr(`IPC_IDX_INPUT_MODE, 8'h01);
		nmiPin <= 1'b1;
		cyc(8);
		check(nmiCount, 2, "nmi rise");
		// Start vector claims the event, then released
		wr(`IPC_IDX_DMA_CH2, 8'h17);
		rd(`IPC_IDX_DMA_CH2, 32'h0, 1'b0);
		wr(`IPC_IDX_TIMER1_0, 8'h03);
		pulse(34'h0_0040_0000);
		cyc(3);
		check(dmaCount, 1, "dma start");
		check(cpuReq, 0, "claimed event");
		wr(`IPC_IDX_DMA_CH2, 8'h00);
		ackQ.push_back({6'h17, 3'h3});
		pulse(34'h0_0040_0000);
		drain();
		check(dmaCount, 1, "dma off");
		results();
	end
endmodule : tb_interrupt_priority_control
